/* File: design/eso_byte_mem.sv */
// Small byte memory holding the display option and user identifier bytes.
`timescale 1ns/1ps
`default_nettype none
module eso_byte_mem
   import eso_pkg::*;
#(
   parameter int DEPTH = 20,
   parameter int AW    = 5
) (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire eso_byte_t     wdata,
   input  wire logic [AW-1:0] raddr,
   output var  eso_byte_t     rdata_q
);
   // Storage array; contents are undefined until software writes them.
   eso_byte_t mem_q [DEPTH];

   // Write port, no reset so the array maps onto plain storage.
   always_ff @(posedge clk) begin
      if (we) begin
         mem_q[waddr] <= wdata;
      end
   end

   // Registered read port; addresses past the end read as zero.
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_q <= 8'h00;
      end else if (int'(raddr) < DEPTH) begin
         rdata_q <= mem_q[raddr];
      end else begin
         rdata_q <= 8'h00;
      end
   end
endmodule
`default_nettype wire

/* File: design/eso_cfg.svh */
// Command codes, reset values, masks and field positions of the option and window commands.
`ifndef ESO_CFG_SVH
`define ESO_CFG_SVH
`define ESO_CMD_HV_DET     8'h14
`define ESO_CMD_VCI_DET    8'h15
`define ESO_CMD_RAM_RD     8'h27
`define ESO_CMD_STATUS     8'h2F
`define ESO_CMD_DISP_OPT   8'h37
`define ESO_CMD_USER_ID    8'h38
`define ESO_CMD_BORDER     8'h3C
`define ESO_CMD_RD_OPT     8'h41
`define ESO_CMD_X_WIN      8'h44
`define ESO_CMD_Y_WIN      8'h45
`define ESO_CMD_RED_FILL   8'h46
`define ESO_CMD_BW_FILL    8'h47
`define ESO_ID_BYTES       4'hA
`define ESO_IDX_MAX        4'hF
`define ESO_IDX_0          4'h0
`define ESO_IDX_1          4'h1
`define ESO_IDX_2          4'h2
`define ESO_IDX_3          4'h3
`define ESO_IDX_4          4'h4
`define ESO_IDX_5          4'h5
`define ESO_MEM_OPT_BASE   5'h00
`define ESO_MEM_UID_BASE   5'h0A
`define ESO_MEM_DEPTH      20
`define ESO_OPT0_MASK      8'h80
`define ESO_OPT5_MASK      8'h4F
`define ESO_OPT_SPARE_BIT  7
`define ESO_OPT_PP_BIT     6
`define ESO_BORDER_RST     8'hC0
`define ESO_BORDER_MASK    8'hF7
`define ESO_FILL_RST       8'h00
`define ESO_FILL_MASK      8'hF7
`define ESO_FILL_H_BAD     3'h7
`define ESO_FILL_W_LAST    3'h5
`define ESO_FILL_H_MAX     9'h128
`define ESO_FILL_W_MAX     8'hB0
`define ESO_FILL_BASE      9'h008
`define ESO_X_START_RST    6'h00
`define ESO_X_END_RST      6'h15
`define ESO_Y_START_RST    9'h000
`define ESO_Y_END_RST      9'h127
`define ESO_RD_OPT_RST     1'h0
`define ESO_ST_HV_BIT      5
`define ESO_ST_VCI_BIT     4
`define ESO_ST_BUSY_BIT    2
`endif

/* File: design/eso_cmd_top.sv */
// Serial command decoder for status, option, border, read plane, window and fill commands.
//
// Summary of operation
// - Status read returns drive voltage readiness bit five.
// - Status bit four reports logic supply low.
// - Status bit two reports controller busy.
// - Chip code in bits one-zero, others zero.
// - Detection bits valid only after start commands.
// - Option byte one bit seven picks spare slot.
// - Option bytes two-six give 36 mode bits.
// - Option byte six bit six enables alternation.
// - Option bytes seven-ten identify module, storable.
// - User identifier takes exactly ten storable bytes.
// - Border byte bits seven-six choose source.
// - Fixed border level from bits five-four.
// - Border bit two chooses red electrode override.
// - Border bits one-zero choose lookup table.
// - Read option bit zero selects read plane.
// - X window start and end, six bits.
// - Y window start and end, nine bits.
// - Red fill command triggers pattern fill.
// - Fill height code seven is refused.
// - Fill width codes six-seven are refused.
// - Memory read from selected plane, dummy first.
// - Window bounds confine writes for address logic.
`timescale 1ns/1ps
`default_nettype none
`include "eso_cfg.svh"
module eso_cmd_top
   import eso_pkg::*;
#(
   parameter logic [1:0] CHIP_CODE = 2'h2 // Arbitrary value, not a real part code.
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        sclk,
   input  wire logic        cs_n,
   input  wire logic        dc,
   input  wire logic        sda_in,
   output var  logic        sda_out,
   output var  logic        sda_oe,
   input  wire logic        drive_voltage_not_ready,
   input  wire logic        logic_supply_check_low,
   input  wire logic        busy_in,
   output var  logic        ram_rd_req,
   output var  logic        ram_rd_plane,
   input  wire eso_byte_t   ram_rd_data,
   input  wire logic        ram_rd_valid,
   input  wire logic [4:0]  otp_addr,
   output var  eso_byte_t   otp_rdata,
   output var  logic        spare_common_electrode_sel,
   output var  logic [35:0] waveform_setting_mode,
   output var  logic        alternating_frame_buffers_en,
   output var  logic [1:0]  border_output_source,
   output var  logic [1:0]  border_output_level,
   output var  logic        border_follow_lut_only,
   output var  logic [1:0]  border_lut_sel,
   output var  logic [5:0]  x_window_start,
   output var  logic [5:0]  x_window_end,
   output var  logic [8:0]  y_window_start,
   output var  logic [8:0]  y_window_end,
   output var  logic        fill_go,
   output var  logic        fill_red_plane,
   output var  logic        fill_first,
   output var  logic [8:0]  fill_height,
   output var  logic [7:0]  fill_width
);
   // ---------------- Serial clock domain ----------------
   logic [2:0] bit_cnt_q;    // Bit position within the current byte.
   logic [6:0] shin_q;       // Bits of the byte received so far.
   eso_byte_t  byte_q;       // Last complete byte, stable until the next one ends.
   logic       dc_q;         // Data/command select captured with that byte.
   logic       tgl_q;        // Flips once per complete byte.
   logic       rd_active_q;  // Device drives the data pin for read bytes.
   logic       rd_status_q;  // Read bytes come from the status byte.
   logic [7:0] out_sh_q;     // Outgoing read byte, shifted on falling edges.
   logic       sda_out_q;    // Data pin output level.
   logic       sda_oe_q;     // Data pin output enable.
   eso_byte_t  status_q;     // Status byte, clock domain.
   eso_byte_t  ram_byte_q;   // Last memory byte fetched, clock domain.

   wire eso_byte_t rx_byte = {shin_q, sda_in};
   wire logic      rx_last = (bit_cnt_q == 3'h7);
   // Status and memory bytes are quasi-static: they settle long before the host shifts them.
   wire eso_byte_t tx_byte = rd_status_q ? status_q : ram_byte_q;

   // Bit counter and read state restart with every chip select frame.
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         bit_cnt_q   <= 3'h0;
         shin_q      <= 7'h00;
         rd_active_q <= 1'b0;
         rd_status_q <= 1'b0;
      end else begin
         bit_cnt_q <= bit_cnt_q + 3'h1;
         shin_q    <= rx_byte[6:0];
         // A command byte with select low decides whether reads follow.
         if (rx_last && !dc) begin
            rd_active_q <= (rx_byte == `ESO_CMD_STATUS) || (rx_byte == `ESO_CMD_RAM_RD);
            rd_status_q <= (rx_byte == `ESO_CMD_STATUS);
         end
      end
   end

   // Complete bytes are handed over by a toggle; the byte itself stays put meanwhile.
   // Reset here is asynchronous because this clock may stand still during reset.
   always_ff @(posedge sclk or posedge rst) begin
      if (rst) begin
         byte_q <= 8'h00;
         dc_q   <= 1'b0;
         tgl_q  <= 1'b0;
      end else if (rx_last) begin
         byte_q <= rx_byte;
         dc_q   <= dc;
         tgl_q  <= ~tgl_q;
      end
   end

   // Read bits leave on falling edges so the host samples them on rising edges.
   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         out_sh_q  <= 8'h00;
         sda_out_q <= 1'b0;
         sda_oe_q  <= 1'b0;
      end else if (rd_active_q) begin
         sda_oe_q <= 1'b1;
         // A new byte starts each time the bit counter has wrapped.
         if (bit_cnt_q == 3'h0) begin
            sda_out_q <= tx_byte[7];
            out_sh_q  <= {tx_byte[6:0], 1'b0};
         end else begin
            sda_out_q <= out_sh_q[7];
            out_sh_q  <= {out_sh_q[6:0], 1'b0};
         end
      end else begin
         sda_oe_q <= 1'b0;
      end
   end

   assign sda_out = sda_out_q;
   assign sda_oe  = sda_oe_q;

   // ---------------- Core clock domain ----------------
   logic tgl_s1_q;  // First synchroniser stage, read only by the second.
   logic tgl_s2_q;  // Second stage.
   logic tgl_s3_q;  // Third stage.
   logic tgl_acc_q; // Toggle level already accepted.

   // Three stage synchroniser for the byte toggle.
   always_ff @(posedge clk) begin
      if (rst) begin
         tgl_s1_q  <= 1'b0;
         tgl_s2_q  <= 1'b0;
         tgl_s3_q  <= 1'b0;
         tgl_acc_q <= 1'b0;
      end else begin
         tgl_s1_q  <= tgl_q;
         tgl_s2_q  <= tgl_s1_q;
         tgl_s3_q  <= tgl_s2_q;
         tgl_acc_q <= (tgl_s2_q == tgl_s3_q) ? tgl_s3_q : tgl_acc_q;
      end
   end

   // A byte counts once stages two and three agree on a new level.
   wire logic ev     = (tgl_s2_q == tgl_s3_q) && (tgl_s3_q != tgl_acc_q);
   wire logic ev_cmd = ev && !dc_q;
   wire logic ev_par = ev && dc_q;

   eso_byte_t  cmd_q; // Command owning the parameter bytes that follow.
   logic [3:0] idx_q; // Index of the next parameter byte, saturating.

   // Command register and parameter index.
   always_ff @(posedge clk) begin
      if (rst) begin
         cmd_q <= 8'h00;
         idx_q <= `ESO_IDX_0;
      end else if (ev_cmd) begin
         cmd_q <= byte_q;
         idx_q <= `ESO_IDX_0;
      end else if (ev_par && idx_q != `ESO_IDX_MAX) begin
         idx_q <= idx_q + 4'h1;
      end
   end

   // Clears parameter bits that are fixed at zero in display option bytes one and six.
   function automatic eso_byte_t opt_mask(input eso_byte_t cmd, input logic [3:0] idx,
                                          input eso_byte_t b);
      eso_byte_t m;
      m = 8'hFF;
      if (cmd == `ESO_CMD_DISP_OPT && idx == `ESO_IDX_0) begin
         m = `ESO_OPT0_MASK;
      end else if (cmd == `ESO_CMD_DISP_OPT && idx == `ESO_IDX_5) begin
         m = `ESO_OPT5_MASK;
      end
      return b & m;
   endfunction

   // Fill step height in rows; code seven has no meaning.
   function automatic logic [8:0] fill_rows(input logic [2:0] code);
      return (code == 3'h6) ? `ESO_FILL_H_MAX : 9'(`ESO_FILL_BASE << code);
   endfunction

   // Fill step width in columns; codes above five have no meaning.
   function automatic logic [7:0] fill_cols(input logic [2:0] code);
      return (code == `ESO_FILL_W_LAST) ? `ESO_FILL_W_MAX : 8'(`ESO_FILL_BASE << code);
   endfunction

   wire logic is_opt  = (cmd_q == `ESO_CMD_DISP_OPT);
   wire logic is_uid  = (cmd_q == `ESO_CMD_USER_ID);
   wire logic first_p = ev_par && (idx_q == `ESO_IDX_0);
   wire eso_byte_t par_byte = opt_mask(cmd_q, idx_q, byte_q);
   // Both identifier commands land in the byte memory, extra bytes are dropped.
   wire logic mem_we = ev_par && (is_opt || is_uid) && (idx_q < `ESO_ID_BYTES);
   wire logic [4:0] mem_waddr = (is_uid ? `ESO_MEM_UID_BASE : `ESO_MEM_OPT_BASE)
                                + {1'b0, idx_q};
   wire logic is_fill = (cmd_q == `ESO_CMD_RED_FILL) || (cmd_q == `ESO_CMD_BW_FILL);
   wire logic fill_ok = (byte_q[6:4] != `ESO_FILL_H_BAD)
                        && (byte_q[2:0] <= `ESO_FILL_W_LAST);

   // All ten option and ten identifier bytes stay readable for one-time programming.
   eso_byte_mem #(
      .DEPTH (`ESO_MEM_DEPTH),
      .AW    (5)
   ) u_id_mem (
      .clk     (clk),
      .rst     (rst),
      .we      (mem_we),
      .waddr   (mem_waddr),
      .wdata   (par_byte),
      .raddr   (otp_addr),
      .rdata_q (otp_rdata)
   );

   logic        spare_q;   // Spare slot select.
   logic [35:0] ws_mode_q; // Display mode per waveform setting.
   logic        pp_q;      // Alternating frame buffer enable.

   // Display option fields that steer the update logic.
   always_ff @(posedge clk) begin
      if (rst) begin
         spare_q   <= 1'b0;
         ws_mode_q <= 36'h0;
         pp_q      <= 1'b0;
      end else if (ev_par && is_opt) begin
         case (idx_q)
            `ESO_IDX_0: spare_q <= par_byte[`ESO_OPT_SPARE_BIT];
            `ESO_IDX_1: ws_mode_q[7:0]   <= par_byte;
            `ESO_IDX_2: ws_mode_q[15:8]  <= par_byte;
            `ESO_IDX_3: ws_mode_q[23:16] <= par_byte;
            `ESO_IDX_4: ws_mode_q[31:24] <= par_byte;
            `ESO_IDX_5: begin
               ws_mode_q[35:32] <= par_byte[3:0];
               pp_q             <= par_byte[`ESO_OPT_PP_BIT];
            end
            default: pp_q <= pp_q; // Bytes seven to ten live only in the memory.
         endcase
      end
   end

   // Alternation only serves display mode 2; the update sequencer ignores it in mode 1.
   assign spare_common_electrode_sel   = spare_q;
   assign waveform_setting_mode        = ws_mode_q;
   assign alternating_frame_buffers_en = pp_q;

   eso_byte_t  border_q; // Border waveform byte.
   logic       rd_opt_q; // Plane returned by memory reads.
   logic [5:0] xs_q;     // X window start.
   logic [5:0] xe_q;     // X window end.
   logic [8:0] ys_q;     // Y window start.
   logic [8:0] ye_q;     // Y window end.

   // Single byte settings; each holds until rewritten.
   always_ff @(posedge clk) begin
      if (rst) begin
         border_q <= `ESO_BORDER_RST;
         rd_opt_q <= `ESO_RD_OPT_RST;
      end else if (first_p && cmd_q == `ESO_CMD_BORDER) begin
         border_q <= byte_q & `ESO_BORDER_MASK;
      end else if (first_p && cmd_q == `ESO_CMD_RD_OPT) begin
         rd_opt_q <= byte_q[0];
      end
   end

   // Source, level, red override and table select are plain fields of the border byte.
   assign border_output_source   = border_q[7:6];
   assign border_output_level    = border_q[5:4];
   assign border_follow_lut_only = border_q[2];
   assign border_lut_sel         = border_q[1:0];

   // Window bounds, which confine the address counter of the write path.
   always_ff @(posedge clk) begin
      if (rst) begin
         xs_q <= `ESO_X_START_RST;
         xe_q <= `ESO_X_END_RST;
         ys_q <= `ESO_Y_START_RST;
         ye_q <= `ESO_Y_END_RST;
      end else if (ev_par && cmd_q == `ESO_CMD_X_WIN) begin
         case (idx_q)
            `ESO_IDX_0: xs_q <= byte_q[5:0];
            `ESO_IDX_1: xe_q <= byte_q[5:0];
            default:    xe_q <= xe_q;
         endcase
      end else if (ev_par && cmd_q == `ESO_CMD_Y_WIN) begin
         case (idx_q)
            `ESO_IDX_0: ys_q[7:0] <= byte_q;
            `ESO_IDX_1: ys_q[8]   <= byte_q[0];
            `ESO_IDX_2: ye_q[7:0] <= byte_q;
            `ESO_IDX_3: ye_q[8]   <= byte_q[0];
            default:    ye_q      <= ye_q;
         endcase
      end
   end

   assign x_window_start = xs_q;
   assign x_window_end   = xe_q;
   assign y_window_start = ys_q;
   assign y_window_end   = ye_q;

   logic       fill_go_q;  // One cycle start pulse for the fill engine.
   logic       fill_red_q; // Fill target is the red plane.
   logic       fill_1st_q; // Value of the first step.
   logic [8:0] fill_h_q;   // Step height in rows.
   logic [7:0] fill_w_q;   // Step width in columns.
   // Reset fill byte as a named constant, so that its size fields can be selected.
   localparam eso_byte_t FILL_RST_BYTE = `ESO_FILL_RST;

   // Pattern fill launch; an illegal size code leaves everything as it was.
   always_ff @(posedge clk) begin
      if (rst) begin
         fill_go_q  <= 1'b0;
         fill_red_q <= 1'b0;
         fill_1st_q <= 1'b0;
         fill_h_q   <= fill_rows(FILL_RST_BYTE[6:4]);
         fill_w_q   <= fill_cols(FILL_RST_BYTE[2:0]);
      end else begin
         fill_go_q <= first_p && is_fill && fill_ok;
         if (first_p && is_fill && fill_ok) begin
            fill_red_q <= (cmd_q == `ESO_CMD_RED_FILL);
            fill_1st_q <= byte_q[7];
            fill_h_q   <= fill_rows(byte_q[6:4]);
            fill_w_q   <= fill_cols(byte_q[2:0]);
         end
      end
   end

   assign fill_go        = fill_go_q;
   assign fill_red_plane = fill_red_q;
   assign fill_first     = fill_1st_q;
   assign fill_height    = fill_h_q;
   assign fill_width     = fill_w_q;

   logic hv_valid_q;  // Drive voltage detection has been started.
   logic vci_valid_q; // Supply check has been started.
   logic ram_req_q;   // Memory fetch request pulse.

   // Detection start commands make the status flags meaningful.
   always_ff @(posedge clk) begin
      if (rst) begin
         hv_valid_q  <= 1'b0;
         vci_valid_q <= 1'b0;
      end else begin
         hv_valid_q  <= hv_valid_q  || (ev_cmd && byte_q == `ESO_CMD_HV_DET);
         vci_valid_q <= vci_valid_q || (ev_cmd && byte_q == `ESO_CMD_VCI_DET);
      end
   end

   // Status byte, refreshed every cycle; unused bits stay zero.
   always_ff @(posedge clk) begin
      if (rst) begin
         status_q <= {6'h00, CHIP_CODE};
      end else begin
         status_q <= {2'b00, hv_valid_q && drive_voltage_not_ready,
                      vci_valid_q && logic_supply_check_low,
                      1'b0, busy_in, CHIP_CODE};
      end
   end

   // Memory reads: the command clears the outgoing byte, which leaves as the dummy byte.
   // Each completed read byte fetches the next one; the fetch must return within half a
   // link clock period, before the next byte starts to shift out.
   always_ff @(posedge clk) begin
      if (rst) begin
         ram_req_q  <= 1'b0;
         ram_byte_q <= 8'h00;
      end else begin
         ram_req_q <= ev_par && cmd_q == `ESO_CMD_RAM_RD;
         if (ev_cmd && byte_q == `ESO_CMD_RAM_RD) begin
            ram_byte_q <= 8'h00;
         end else if (ram_rd_valid) begin
            ram_byte_q <= ram_rd_data;
         end
      end
   end

   assign ram_rd_req   = ram_req_q;
   assign ram_rd_plane = rd_opt_q;

   // ---------------- Checks ----------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_status_fixed;
      status_q[7:6] == 2'b00 && status_q[3] == 1'b0 && status_q[1:0] == CHIP_CODE;
   endproperty
   a_status_fixed: assert property (p_status_fixed) else $error("status fixed bits wrong");

   property p_hv_flag;
      hv_valid_q && drive_voltage_not_ready |=> status_q[`ESO_ST_HV_BIT];
   endproperty
   a_hv_flag: assert property (p_hv_flag) else $error("drive voltage flag not set");

   property p_vci_invalid;
      !vci_valid_q |=> !status_q[`ESO_ST_VCI_BIT];
   endproperty
   a_vci_invalid: assert property (p_vci_invalid) else $error("supply flag set early");

   property p_busy;
      busy_in == 1'b1 ##1 busy_in == 1'b0 |-> status_q[`ESO_ST_BUSY_BIT] ##1
         !status_q[`ESO_ST_BUSY_BIT];
   endproperty
   a_busy: assert property (p_busy) else $error("busy flag does not follow");

   property p_border;
      first_p && cmd_q == `ESO_CMD_BORDER |=> border_q == ($past(byte_q) & `ESO_BORDER_MASK);
   endproperty
   a_border: assert property (p_border) else $error("border byte not stored");

   property p_border_zero;
      border_q[3] == 1'b0;
   endproperty
   a_border_zero: assert property (p_border_zero) else $error("border fixed bit set");

   property p_rd_plane;
      first_p && cmd_q == `ESO_CMD_RD_OPT |=> ram_rd_plane == $past(byte_q[0]);
   endproperty
   a_rd_plane: assert property (p_rd_plane) else $error("read plane not updated");

   property p_x_start;
      ev_par && cmd_q == `ESO_CMD_X_WIN && idx_q == `ESO_IDX_0 |=>
         x_window_start == $past(byte_q[5:0]);
   endproperty
   a_x_start: assert property (p_x_start) else $error("x start not stored");

   property p_y_end_hi;
      ev_par && cmd_q == `ESO_CMD_Y_WIN && idx_q == `ESO_IDX_3 |=>
         y_window_end[8] == $past(byte_q[0]) && $stable(y_window_start);
   endproperty
   a_y_end_hi: assert property (p_y_end_hi) else $error("y end high bit wrong");

   property p_fill_refuse;
      first_p && is_fill && byte_q[6:4] == `ESO_FILL_H_BAD |=> !fill_go;
   endproperty
   a_fill_refuse: assert property (p_fill_refuse) else $error("illegal fill height run");

   property p_ram_req;
      ev_par && cmd_q == `ESO_CMD_RAM_RD |=> ram_rd_req ##1 !ram_rd_req;
   endproperty
   a_ram_req: assert property (p_ram_req) else $error("memory fetch not one pulse");
endmodule
`default_nettype wire

/* File: design/eso_pkg.sv */
// Types shared by the option and window command block.
package eso_pkg;
   typedef logic [7:0] eso_byte_t;
   // Border output sources in the order of their two-bit code.
   typedef enum logic [1:0] {
      ESO_BORDER_GREY_SCALE,
      ESO_BORDER_FIXED_LEVEL,
      ESO_BORDER_COMMON_ELECTRODE,
      ESO_BORDER_HIGH_Z
   } eso_border_src_t;
endpackage

/* File: sim/eso_host_model.sv */
// Host controller model that sends command frames over the serial link.
`timescale 1ns/1ps
`default_nettype none
module eso_host_model (
   output var  logic sclk,
   output var  logic cs_n,
   output var  logic dc,
   output var  logic sda_in,
   input  wire logic sda_out,
   input  wire logic sda_oe
);
   // The link clock stands low and the select high between frames.
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      dc = 1'b0;
      sda_in = 1'b0;
   end
   // Sends a command byte and n parameter bytes, sampling read data on rising edges.
   task automatic frame(input logic [7:0] c, input logic [7:0] p [10], input int n,
                        output logic [7:0] r [10]);
      logic [7:0] b;
      cs_n = 1'b0;
      for (int k = 0; k <= n; k++) begin
         b = (k == 0) ? c : p[k-1];
         for (int i = 7; i >= 0; i--) begin
            sclk = 1'b0;
            dc = (k != 0);
            sda_in = b[i];
            #62.5;
            sclk = 1'b1;
            if (k != 0) r[k-1][i] = sda_oe ? sda_out : 1'bx;
            #62.5;
         end
      end
      sclk = 1'b0;
      #62.5;
      cs_n = 1'b1;
      // A released data line must not keep showing the last bit.
      sda_in = ~sda_in;
   endtask
endmodule
`default_nettype wire

/* File: sim/tb_epd_status_option_window_cmds.sv */
// Self-checking bench for the status, option, border, window and fill decoder.
`timescale 1ns/1ps
`default_nettype none
`include "eso_cfg.svh"
module tb_epd_status_option_window_cmds;
   import eso_pkg::*;
   logic clk = 1'b0, rst = 1'b1, sclk, cs_n, dc, sda_in, sda_out, sda_oe, ram_rd_req;
   logic drive_voltage_not_ready = 1'b0, logic_supply_check_low = 1'b0, busy_in = 1'b0;
   logic ram_rd_plane, ram_rd_valid = 1'b0, spare_common_electrode_sel, fill_go, ok;
   logic alternating_frame_buffers_en, border_follow_lut_only, fill_red_plane, fill_first;
   logic [1:0] border_output_source, border_output_level, border_lut_sel, ef = 2'h0;
   logic [5:0] x_window_start, x_window_end;
   logic [8:0] y_window_start, y_window_end, fill_height, eh = 9'h008;
   logic [7:0] fill_width, b, ew = 8'h08, p [10], r [10];
   logic [7:0] cor [4] = '{8'hE5, 8'h70, 8'h06, 8'h08};
   logic [35:0] waveform_setting_mode;
   logic [4:0] otp_addr = 5'h00;
   eso_byte_t ram_rd_data = 8'h00, otp_rdata;
   logic [31:0] seed = 32'h0000F85C;
   int bad_count = 0, n_tests = 0, fills = 0, f0;
   eso_cmd_top u_dut (.*);
   eso_host_model u_host (.*);
   always #5 clk = ~clk;
   // Frame memory stand-in: answers each fetch one cycle later with plane-specific data.
   always @(posedge clk) begin
      ram_rd_valid <= ram_rd_req;
      ram_rd_data <= ram_rd_plane ? 8'hA5 : 8'h3C;
      if (fill_go === 1'b1) fills <= fills + 1;
   end
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   function automatic logic [8:0] hgt(input logic [2:0] c);
      return (c == 3'h6) ? 9'h128 : 9'h008 << c;
   endfunction
   function automatic logic [7:0] wid(input logic [2:0] c);
      return (c == 3'h5) ? 8'hB0 : 8'h08 << c;
   endfunction
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Sends one frame, then leaves room for the crossing into the core clock.
   task automatic run(input logic [7:0] c, input int n);
      u_host.frame(c, p, n, r);
      repeat (8) @(posedge clk);
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      #900000;
      bad_count++;
      stop_test();
   end
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
      chk({border_output_source, border_output_level, border_lut_sel}, 6'h30);
      chk({x_window_start, x_window_end, ram_rd_plane}, 13'h002A);
      chk({y_window_start, y_window_end}, 18'h00127);
      chk(alternating_frame_buffers_en, 1'b0);
      drive_voltage_not_ready <= 1'b1;
      logic_supply_check_low <= 1'b1;
      busy_in <= 1'b1;
      run(`ESO_CMD_STATUS, 1);
      chk(r[0], 8'h06);
      run(`ESO_CMD_HV_DET, 0);
      run(`ESO_CMD_VCI_DET, 0);
      run(`ESO_CMD_STATUS, 1);
      chk(r[0], 8'h36);
      drive_voltage_not_ready <= 1'b0;
      busy_in <= 1'b0;
      run(`ESO_CMD_STATUS, 2);
      chk({r[0], r[1]}, 16'h1212);
      // Corner bytes first, then random ones, through every single-byte command.
      for (int k = 0; k < 12; k++) begin
         b = (k < 4) ? cor[k] : rnd();
         p[0] = b;
         run(`ESO_CMD_BORDER, 1);
         chk({border_output_source, border_output_level, border_follow_lut_only,
              border_lut_sel}, {b[7:4], b[2:0]});
         p[1] = ~b;
         run(`ESO_CMD_X_WIN, 2);
         chk({x_window_start, x_window_end}, {b[5:0], ~b[5:0]});
         p[1] = b;
         p[2] = ~b;
         p[3] = ~b;
         run(`ESO_CMD_Y_WIN, 4);
         chk({y_window_start, y_window_end}, {b[0], b, ~b[0], ~b});
         p[0] = b;
         run(`ESO_CMD_RD_OPT, 1);
         chk(ram_rd_plane, b[0]);
         run(`ESO_CMD_RAM_RD, 2);
         chk({r[0], r[1]}, {8'h00, b[0] ? 8'hA5 : 8'h3C});
         ok = (b[6:4] != 3'h7) && (b[2:0] < 3'h6);
         if (ok) begin
            eh = hgt(b[6:4]);
            ew = wid(b[2:0]);
            ef = {k[0], b[7]};
         end
         f0 = fills;
         run(k[0] ? `ESO_CMD_RED_FILL : `ESO_CMD_BW_FILL, 1);
         chk(fills - f0, ok);
         chk({fill_height, fill_width, fill_red_plane, fill_first}, {eh, ew, ef});
      end
      for (int m = 0; m < 2; m++) begin
         for (int i = 0; i < 10; i++) p[i] = rnd();
         run(m ? `ESO_CMD_USER_ID : `ESO_CMD_DISP_OPT, 10);
         for (int i = 0; i < 10; i++) begin
            otp_addr <= 5'(10 * m + i);
            repeat (2) @(posedge clk);
            chk(otp_rdata, (m == 0 && i == 0) ? p[0] & 8'h80 :
                (m == 0 && i == 5) ? p[5] & 8'h4F : p[i]);
         end
         if (m == 0) begin
            chk({spare_common_electrode_sel, alternating_frame_buffers_en},
                {p[0][7], p[5][6]});
            chk(waveform_setting_mode, {p[5][3:0], p[4], p[3], p[2], p[1]});
         end
      end
      stop_test();
   end
endmodule
`default_nettype wire
